// [rtl/pio_command_protocol.sv]
// command layer of an eight-channel programmable i/o slave
// assumes a bit layer that delivers whole bytes and requests answer bytes
`timescale 1ns/10ps
`default_nettype none
`include "pio_cmd_defs.svh"

module pio_command_protocol
  import pio_cmd_pkg::*;
#(
  parameter int DATA_VALID_STROBE_CYCLES = `DATA_VALID_STROBE_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // bit layer events
  input  wire logic       bus_reset,
  input  wire logic       rom_selected,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       tx_req,
  output logic            tx_valid_r,
  output logic      [7:0] tx_byte_r,
  // pio pins, open drain
  input  wire logic [7:0] pio_in,
  output logic      [7:0] pio_out_r,
  output logic      [7:0] pio_oe_n_r,
  // reset or strobe pin, open drain
  input  wire logic       rst_data_valid_strobe_in,
  output logic            rst_data_valid_strobe_out_r,
  output logic            rst_data_valid_strobe_oe_n_r
);

  cmd_state_t  state_r;
  logic [7:0]  cmd_r;
  logic [7:0]  addr_r;
  logic [7:0]  new_r;
  logic [7:0]  latch_r;
  logic [7:0]  sel_mask_r;
  logic [7:0]  pol_sel_r;
  logic [7:0]  ctrl_r;
  logic [5:0]  smp_cnt_r;
  logic [15:0] data_valid_strobe_cnt_r;
  logic [15:0] crc_r;
  logic        crc_clr;
  logic        crc_en;
  logic [7:0]  crc_din;
  logic [7:0]  page_byte;
  logic        good_pair;
  logic        strobe_evt;

  // page read mux
  always_comb begin
    unique case (addr_r)
      `ADDR_PIN_STATE: page_byte = pio_in;
      `ADDR_OUT_LATCH: page_byte = latch_r;
      `ADDR_SEL_MASK:  page_byte = sel_mask_r;
      `ADDR_POL_SEL:   page_byte = pol_sel_r;
      `ADDR_CTRL_STAT: page_byte = ctrl_r | `CS_SET_BITS;
      default:         page_byte = 8'h00;
    endcase
  end

  assign good_pair  = (state_r == ST_OUT_INV) && rx_valid && (rx_byte == ~new_r);
  assign strobe_evt = good_pair || (tx_req && state_r == ST_SMP_DATA);

  // crc feed
  always_comb begin
    crc_clr = 1'b0;
    crc_en  = 1'b0;
    crc_din = rx_byte;
    if (rom_selected || bus_reset) begin
      crc_clr = 1'b1;
    end else if (rx_valid && (state_r == ST_CMD || state_r == ST_TA1 || state_r == ST_TA2)) begin
      crc_en = 1'b1;
    end else if (tx_req && state_r == ST_REG_DATA) begin
      crc_en  = 1'b1;
      crc_din = page_byte;
    end else if (tx_req && state_r == ST_SMP_DATA) begin
      crc_en  = 1'b1;
      crc_din = pio_in;
    end else if (tx_req && state_r == ST_SMP_CRCH) begin
      crc_clr = 1'b1;
    end
  end

  crc16_unit u_crc (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .crc_clr (crc_clr),
    .crc_en  (crc_en),
    .crc_din (crc_din),
    .crc_r   (crc_r)
  );

  // command sequencer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_IDLE;
      cmd_r     <= 8'h00;
      addr_r    <= 8'h00;
      new_r     <= 8'h00;
      smp_cnt_r <= 6'd0;
    end else if (bus_reset) begin
      state_r <= ST_IDLE;
    end else if (rom_selected) begin
      state_r <= ST_CMD;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_FILL, ST_REG_CRCH, ST_OUT_CONF, ST_OUT_RDBK,
        ST_REG_CRCL, ST_SMP_CRCL, ST_SMP_CRCH, ST_REG_DATA, ST_SMP_DATA: begin
          if (tx_req) begin
            unique case (state_r)
              ST_REG_DATA: state_r <= (addr_r == `ADDR_PAGE_LAST) ? ST_REG_CRCL : ST_REG_DATA;
              ST_REG_CRCL: state_r <= ST_REG_CRCH;
              ST_REG_CRCH: state_r <= ST_FILL;
              ST_SMP_CRCL: state_r <= ST_SMP_CRCH;
              ST_SMP_CRCH: state_r <= ST_SMP_DATA;
              ST_OUT_CONF: state_r <= ST_OUT_RDBK;
              ST_OUT_RDBK: state_r <= ST_OUT_NEW;
              ST_SMP_DATA: state_r <= (smp_cnt_r == `SAMPLES_PER_BLOCK - 6'd1)
                                      ? ST_SMP_CRCL : ST_SMP_DATA;
              default:     state_r <= state_r;
            endcase
            if (state_r == ST_REG_DATA) begin
              addr_r <= addr_r + 8'd1;
            end
            if (state_r == ST_SMP_DATA) begin
              smp_cnt_r <= (smp_cnt_r == `SAMPLES_PER_BLOCK - 6'd1) ? 6'd0 : smp_cnt_r + 6'd1;
            end
          end
        end
        ST_CMD: begin
          if (rx_valid) begin
            cmd_r     <= rx_byte;
            smp_cnt_r <= 6'd0;
            unique case (rx_byte)
              `CMD_REG_READ, `CMD_SEARCH_WRITE: state_r <= ST_TA1;
              `CMD_SAMPLE_READ:                 state_r <= ST_SMP_DATA;
              `CMD_OUT_WRITE:                   state_r <= ST_OUT_NEW;
              default:                          state_r <= ST_FILL;
            endcase
          end
        end
        ST_TA1: begin
          if (rx_valid) begin
            addr_r  <= rx_byte;
            state_r <= ST_TA2;
          end
        end
        ST_TA2: begin
          if (rx_valid) begin
            if (cmd_r == `CMD_REG_READ) begin
              state_r <= (rx_byte == `PAGE_HIGH && addr_r >= `ADDR_PIN_STATE
                          && addr_r <= `ADDR_PAGE_LAST) ? ST_REG_DATA : ST_FILL;
            end else begin
              state_r <= (rx_byte == `PAGE_HIGH && addr_r >= `ADDR_SEL_MASK
                          && addr_r <= `ADDR_CTRL_STAT) ? ST_SRCH_DAT : ST_FILL;
            end
          end
        end
        ST_SRCH_DAT: begin
          if (rx_valid && addr_r <= `ADDR_CTRL_STAT) begin
            addr_r <= addr_r + 8'd1;
          end
        end
        ST_OUT_NEW: begin
          if (rx_valid) begin
            new_r   <= rx_byte;
            state_r <= ST_OUT_INV;
          end
        end
        ST_OUT_INV: begin
          if (rx_valid) begin
            state_r <= good_pair ? ST_OUT_CONF : ST_FILL;
          end
        end
      endcase
    end
  end

  // search registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_mask_r <= `MASK_RESET;
      pol_sel_r  <= `MASK_RESET;
      ctrl_r     <= `CS_RESET;
    end else if (state_r == ST_SRCH_DAT && rx_valid && !bus_reset && !rom_selected) begin
      unique case (addr_r)
        `ADDR_SEL_MASK:  sel_mask_r <= rx_byte;
        `ADDR_POL_SEL:   pol_sel_r  <= rx_byte;
        `ADDR_CTRL_STAT: ctrl_r <= rx_byte & `CS_WMASK;
        default:         ctrl_r <= ctrl_r;
      endcase
    end
  end

  // output latches
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_r <= `LATCH_RESET;
    end else if (!ctrl_r[`CS_STROBE_BIT] && !rst_data_valid_strobe_in) begin
      latch_r <= `LATCH_RESET;
    end else if (good_pair && !bus_reset && !rom_selected) begin
      latch_r <= new_r;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pio_out_r  <= 8'h00;
      pio_oe_n_r <= 8'hFF;
    end else begin
      pio_out_r  <= 8'h00;
      pio_oe_n_r <= latch_r;
    end
  end

  // answer bytes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_valid_r <= 1'b0;
      tx_byte_r  <= `BYTE_FILL;
    end else begin
      tx_valid_r <= tx_req;
      if (tx_req) begin
        unique case (state_r)
          ST_REG_DATA: tx_byte_r <= page_byte;
          ST_REG_CRCL, ST_SMP_CRCL: tx_byte_r <= ~crc_r[7:0];
          ST_REG_CRCH, ST_SMP_CRCH: tx_byte_r <= ~crc_r[15:8];
          ST_SMP_DATA: tx_byte_r <= pio_in;
          ST_OUT_CONF: tx_byte_r <= `BYTE_CONFIRM;
          ST_OUT_RDBK: tx_byte_r <= pio_in;
          default:     tx_byte_r <= `BYTE_FILL;
        endcase
      end
    end
  end

  // data strobe pulse
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_valid_strobe_cnt_r      <= 16'd0;
      rst_data_valid_strobe_out_r  <= 1'b0;
      rst_data_valid_strobe_oe_n_r <= 1'b1;
    end else begin
      if (strobe_evt && ctrl_r[`CS_STROBE_BIT]) begin
        data_valid_strobe_cnt_r <= 16'(DATA_VALID_STROBE_CYCLES);
      end else if (data_valid_strobe_cnt_r != 16'd0) begin
        data_valid_strobe_cnt_r <= data_valid_strobe_cnt_r - 16'd1;
      end
      rst_data_valid_strobe_out_r  <= 1'b0;
      rst_data_valid_strobe_oe_n_r <= !(ctrl_r[`CS_STROBE_BIT] && data_valid_strobe_cnt_r != 16'd0);
    end
  end

endmodule // pio_command_protocol

`default_nettype wire

// [rtl/pio_cmd_defs.svh]
// constants of the programmable i/o command layer
// assumes byte-wide traffic from the single-wire bit layer, lsb first
`ifndef PIO_CMD_DEFS_SVH
`define PIO_CMD_DEFS_SVH

// command codes
`define CMD_REG_READ      8'hF0
`define CMD_SAMPLE_READ   8'hF5
`define CMD_OUT_WRITE     8'h5A
`define CMD_SEARCH_WRITE  8'hCC

// fixed answers
`define BYTE_FILL         8'hFF
`define BYTE_CONFIRM      8'hAA

// register page, high address byte must be this
`define PAGE_HIGH         8'h00
`define ADDR_PIN_STATE    8'h88
`define ADDR_OUT_LATCH    8'h89
`define ADDR_ACTIVITY     8'h8A
`define ADDR_SEL_MASK     8'h8B
`define ADDR_POL_SEL      8'h8C
`define ADDR_CTRL_STAT    8'h8D
`define ADDR_PAGE_LAST    8'h8F

// control_status fields and register reset values
`define CS_WMASK          8'h0F
`define CS_SET_BITS       8'h80
`define CS_STROBE_BIT     2
`define CS_RESET          8'h00
`define LATCH_RESET       8'hFF
`define MASK_RESET        8'h00

// stream framing and crc
`define SAMPLES_PER_BLOCK 6'd32
`define CRC_POLY_REFL     16'hA001

// data strobe width
`define DATA_VALID_STROBE_NS           1000
`define CLK_NS            20
`define DATA_VALID_STROBE_CYC          ((`DATA_VALID_STROBE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [rtl/pio_cmd_pkg.sv]
// types of the programmable i/o command layer
package pio_cmd_pkg;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_CMD      = 4'h1,
    ST_TA1      = 4'h2,
    ST_TA2      = 4'h3,
    ST_REG_DATA = 4'h4,
    ST_REG_CRCL = 4'h5,
    ST_REG_CRCH = 4'h6,
    ST_SMP_DATA = 4'h7,
    ST_SMP_CRCL = 4'h8,
    ST_SMP_CRCH = 4'h9,
    ST_OUT_NEW  = 4'hA,
    ST_OUT_INV  = 4'hB,
    ST_OUT_CONF = 4'hC,
    ST_OUT_RDBK = 4'hD,
    ST_SRCH_DAT = 4'hE,
    ST_FILL     = 4'hF
  } cmd_state_t;

endpackage

// [rtl/crc16_unit.sv]
// byte-wide crc16 generator, lsb first, polynomial x16+x15+x2+1
// clear has priority over a byte shifted in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "pio_cmd_defs.svh"

module crc16_unit (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // control
  input  wire logic        crc_clr,
  input  wire logic        crc_en,
  input  wire logic [7:0]  crc_din,
  // result
  output logic      [15:0] crc_r
);

  logic [15:0] crc_nxt;

  always_comb begin
    crc_nxt = crc_r;
    for (int i = 0; i < 8; i++) begin
      if (crc_nxt[0] ^ crc_din[i]) begin
        crc_nxt = (crc_nxt >> 1) ^ `CRC_POLY_REFL;
      end else begin
        crc_nxt = crc_nxt >> 1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_r <= 16'h0000;
    end else if (crc_clr) begin
      crc_r <= 16'h0000;
    end else if (crc_en) begin
      crc_r <= crc_nxt;
    end
  end

endmodule // crc16_unit

`default_nettype wire

// [tb/pio_bus_master.sv]
// behavioural single-wire bus master at the byte level
// assumes the device answers a read request one cycle later
`timescale 1ns/10ps
`default_nettype none
module pio_bus_master (
  // clock
  input  wire logic       sys_clk,
  // answers from device
  input  wire logic       tx_valid_r,
  input  wire logic [7:0] tx_byte_r,
  // requests to device
  output logic            bus_reset,
  output logic            rom_selected,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            tx_req
);
  initial begin
    bus_reset = 1'b0;
    rom_selected = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'hFF;
    tx_req = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic sel(input logic do_sel);
    bus_reset = 1'b1;
    step(1);
    bus_reset = 1'b0;
    step(1);
    if (do_sel) begin
      rom_selected = 1'b1;
      step(1);
      rom_selected = 1'b0;
      step(2);
    end
  endtask
  task automatic wr(input logic [7:0] v);
    rx_byte = v;
    rx_valid = 1'b1;
    step(1);
    rx_valid = 1'b0;
    rx_byte = ~v;
    step(8);
  endtask
  task automatic rd(output logic [7:0] v);
    tx_req = 1'b1;
    step(1);
    tx_req = 1'b0;
    v = tx_byte_r;
    step(8);
  endtask
endmodule // pio_bus_master
`default_nettype wire

// [tb/pio_cmd_properties.sv]
// assertions on the command layer ports
// assumes binding onto pio_command_protocol
`timescale 1ns/10ps
`default_nettype none
`include "pio_cmd_defs.svh"
module pio_cmd_properties #(
  parameter int DATA_VALID_STROBE_CYCLES = `DATA_VALID_STROBE_CYC
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // byte link
  input wire logic       bus_reset,
  input wire logic       rom_selected,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic       tx_req,
  input wire logic       tx_valid_r,
  input wire logic [7:0] tx_byte_r,
  // pins
  input wire logic [7:0] pio_in,
  input wire logic [7:0] pio_out_r,
  input wire logic [7:0] pio_oe_n_r,
  input wire logic       rst_data_valid_strobe_in,
  input wire logic       rst_data_valid_strobe_out_r,
  input wire logic       rst_data_valid_strobe_oe_n_r
);
  logic [7:0] low_cnt_r;
  logic       rx_pend_r;
  logic       aa_seen_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // strobe low time
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      low_cnt_r <= 8'h00;
    else if (rst_data_valid_strobe_oe_n_r)
      low_cnt_r <= 8'h00;
    else
      low_cnt_r <= low_cnt_r + 8'h01;
  end
  // confirmation answered right after a pair
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_pend_r <= 1'b0;
      aa_seen_r <= 1'b0;
    end else if (rx_valid) begin
      rx_pend_r <= 1'b1;
    end else if (tx_valid_r) begin
      rx_pend_r <= 1'b0;
      aa_seen_r <= rx_pend_r && (tx_byte_r == 8'hAA);
    end
  end
  property p_answer_next;
    tx_req |=> tx_valid_r;
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("no answer after read");
  property p_answer_cause;
    tx_valid_r |-> $past(tx_req);
  endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("answer without read");
  property p_byte_holds;
    $changed(tx_byte_r) |-> tx_valid_r;
  endproperty
  a_byte_holds: assert property (p_byte_holds) else $error("answer byte moved");
  property p_open_drain;
    pio_out_r == 8'h00 && !rst_data_valid_strobe_out_r;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_latch_pair;
    $changed(pio_oe_n_r) |-> ($past(rx_valid, 2) && pio_oe_n_r == ~$past(rx_byte, 2))
      || (!$past(rst_data_valid_strobe_in, 2) && pio_oe_n_r == 8'hFF);
  endproperty
  a_latch_pair: assert property (p_latch_pair) else $error("latch moved wrongly");
  property p_readback;
    tx_req && aa_seen_r |=> tx_byte_r == $past(pio_in);
  endproperty
  a_readback: assert property (p_readback) else $error("readback not pin state");
  property p_strobe_len;
    $rose(rst_data_valid_strobe_oe_n_r) |-> low_cnt_r == 8'(DATA_VALID_STROBE_CYCLES);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");
  property p_idle_fill;
    bus_reset ##1 !rom_selected ##1 tx_req |=> tx_byte_r == 8'hFF;
  endproperty
  a_idle_fill: assert property (p_idle_fill) else $error("idle read not FF");
endmodule // pio_cmd_properties
bind pio_command_protocol pio_cmd_properties #(.DATA_VALID_STROBE_CYCLES(DATA_VALID_STROBE_CYCLES)) u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .bus_reset(bus_reset), .rom_selected(rom_selected),
  .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req), .tx_valid_r(tx_valid_r),
  .tx_byte_r(tx_byte_r), .pio_in(pio_in), .pio_out_r(pio_out_r), .pio_oe_n_r(pio_oe_n_r),
  .rst_data_valid_strobe_in(rst_data_valid_strobe_in), .rst_data_valid_strobe_out_r(rst_data_valid_strobe_out_r),
  .rst_data_valid_strobe_oe_n_r(rst_data_valid_strobe_oe_n_r));
`default_nettype wire

// [tb/tb.sv]
// self-checking bench of the command layer
// assumes open-drain pins with pull-ups and a byte-level master
`timescale 1ns/10ps
`default_nettype none
`include "pio_cmd_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        bus_reset, rom_selected, rx_valid, tx_req, tx_valid_r;
  logic        rst_data_valid_strobe_out_r, rst_data_valid_strobe_oe_n_r;
  logic [7:0]  rx_byte, tx_byte_r, pio_out_r, pio_oe_n_r, b, n, lat, e;
  logic [7:0]  ext_r = 8'hFF;
  logic        rst_ext_r = 1'b1;
  logic [15:0] crc;
  int          failures = 0;
  int          checks = 0;
  int          seed = 32'h4f974387;
  wire [7:0]   pio_in = pio_oe_n_r & ext_r;
  // reset pin pulled up, low by strobe or by the outside
  wire         rst_pin = rst_data_valid_strobe_oe_n_r & rst_ext_r;
  always #10 sys_clk = ~sys_clk;
  pio_command_protocol #(.DATA_VALID_STROBE_CYCLES(4)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus_reset(bus_reset), .rom_selected(rom_selected), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_req(tx_req), .tx_valid_r(tx_valid_r), .tx_byte_r(tx_byte_r),
    .pio_in(pio_in), .pio_out_r(pio_out_r), .pio_oe_n_r(pio_oe_n_r),
    .rst_data_valid_strobe_in(rst_pin), .rst_data_valid_strobe_out_r(rst_data_valid_strobe_out_r),
    .rst_data_valid_strobe_oe_n_r(rst_data_valid_strobe_oe_n_r));
  pio_bus_master u_master (.sys_clk(sys_clk), .tx_valid_r(tx_valid_r),
    .tx_byte_r(tx_byte_r), .bus_reset(bus_reset), .rom_selected(rom_selected),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req));
  function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction
  task automatic hdr(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    u_master.sel(1'b1);
    u_master.wr(c);
    u_master.wr(lo);
    u_master.wr(hi);
  endtask
  task automatic finish_test();
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    failures++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    u_master.sel(1'b0);
    u_master.rd(b);
    `CHK(b, `BYTE_FILL)
    // pin still a reset input: pulling it low sets the latches back to all ones
    u_master.sel(1'b1);
    u_master.wr(`CMD_OUT_WRITE);
    u_master.wr(8'h3C);
    u_master.wr(8'hC3);
    u_master.rd(b);
    `CHK(b, `BYTE_CONFIRM)
    `CHK(pio_oe_n_r, 8'h3C)
    rst_ext_r = 1'b0;
    u_master.step(3);
    `CHK(pio_oe_n_r, `LATCH_RESET)
    rst_ext_r = 1'b1;
    n = 8'($random(seed));
    hdr(`CMD_SEARCH_WRITE, 8'h8B, 8'h00);
    u_master.wr(n);
    u_master.wr(~n);
    u_master.wr(8'h04);
    // past the last search register: must be ignored
    u_master.wr(8'h5C);
    u_master.rd(b);
    `CHK(b, `BYTE_FILL)
    hdr(`CMD_SEARCH_WRITE, 8'h80, 8'h00);
    u_master.wr(8'h00);
    u_master.rd(b);
    `CHK(b, `BYTE_FILL)
    hdr(`CMD_REG_READ, 8'h8B, 8'h00);
    crc = crc_add(crc_add(crc_add(16'h0000, 8'hF0), 8'h8B), 8'h00);
    for (int a = 0; a < 5; a++) begin
      e = (a == 0) ? n : (a == 1) ? ~n : (a == 2) ? 8'h84 : 8'h00;
      u_master.rd(b);
      `CHK(b, e)
      crc = crc_add(crc, e);
    end
    u_master.rd(b);
    `CHK(b, ~crc[7:0])
    u_master.rd(b);
    `CHK(b, ~crc[15:8])
    u_master.rd(b);
    `CHK(b, `BYTE_FILL)
    for (int i = 0; i < 2; i++) begin
      hdr(`CMD_REG_READ, i ? 8'h8D : 8'h87, i ? 8'h01 : 8'h00);
      u_master.rd(b);
      `CHK(b, `BYTE_FILL)
    end
    u_master.sel(1'b1);
    u_master.wr(`CMD_OUT_WRITE);
    for (int i = 0; i < 5; i++) begin
      n = (i == 0) ? 8'h00 : 8'($random(seed));
      ext_r = 8'($random(seed));
      u_master.wr(n);
      u_master.wr(~n);
      lat = n;
      u_master.rd(b);
      `CHK(b, `BYTE_CONFIRM)
      u_master.rd(b);
      `CHK(b, lat & ext_r)
    end
    for (int i = 0; i < 2; i++) begin
      n = 8'($random(seed));
      u_master.wr(n);
      u_master.wr(i ? ~n : (~n ^ 8'h10));
      u_master.rd(b);
      `CHK(b, `BYTE_FILL)
      `CHK(pio_oe_n_r, lat)
    end
    u_master.sel(1'b1);
    u_master.wr(`CMD_SAMPLE_READ);
    crc = crc_add(16'h0000, `CMD_SAMPLE_READ);
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 32; s++) begin
        ext_r = 8'($random(seed));
        u_master.rd(b);
        `CHK(b, lat & ext_r)
        crc = crc_add(crc, lat & ext_r);
      end
      u_master.rd(b);
      `CHK(b, ~crc[7:0])
      u_master.rd(b);
      `CHK(b, ~crc[15:8])
      crc = 16'h0000;
    end
    finish_test();
  end
endmodule // tb
`default_nettype wire
